/* File: hw/readout_defines.svh */
// Constants of the humidity and temperature readout: bus codes, status layout and timing.
`ifndef READOUT_DEFINES_SVH
`define READOUT_DEFINES_SVH

// ==========================================================================
// Bus addressing and command bytes
`define RDO_DEV_ADDR 7'h38
`define RDO_READ_ADDR_BYTE 8'h71
`define RDO_TRIG_BYTE0 8'hac
`define RDO_TRIG_BYTE1 8'h33
`define RDO_TRIG_BYTE2 8'h00
`define RDO_TRIG_LAST_IDX 3'h2

// ==========================================================================
// Read payload layout
`define RDO_READ_BYTES 3'h7
`define RDO_CRC_IDX 3'h6
`define RDO_FILL_BYTE 8'hff

// ==========================================================================
// Check byte
`define RDO_CRC_INIT 8'hff
`define RDO_CRC_POLY 8'h31

// ==========================================================================
// Status byte field positions
`define RDO_ST_BUSY 7
`define RDO_ST_MODE_HI 6
`define RDO_ST_MODE_LO 5
`define RDO_ST_OTP_OK 4
`define RDO_ST_CAL_EN 3
`define RDO_ST_OUT_WIN 2
`define RDO_ST_RSVD 2'h0
`define RDO_STATUS_RESET 8'h00

// ==========================================================================
// Timing
`define RDO_CLK_HZ 125000000
`define RDO_CONV_TIME_MS 80
`define RDO_CONV_CYCLES (`RDO_CONV_TIME_MS * (`RDO_CLK_HZ / 1000))

`endif

/* File: hw/readout_pkg.sv */
// Types shared by the humidity and temperature readout.
package readout_pkg;

  // ========================================================================
  // Bus engine states
  typedef enum logic [2:0] {
    LINK_IDLE = 3'b000,
    LINK_ADDR = 3'b001,
    LINK_ADDR_ACK = 3'b010,
    LINK_WRITE = 3'b011,
    LINK_WRITE_ACK = 3'b100,
    LINK_READ = 3'b101,
    LINK_READ_ACK = 3'b110
  } link_state_t;

  // ========================================================================
  // Measurement engine states
  typedef enum logic [1:0] {
    MEAS_AWAKE = 2'b00,
    MEAS_CONVERT = 2'b01,
    MEAS_SLEEP = 2'b10
  } meas_state_t;

  // ========================================================================
  // Working mode reported in the status byte
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_CYCLIC = 2'b01,
    MODE_COMMAND = 2'b10
  } work_mode_t;

endpackage

/* File: hw/pin_sync.sv */
// Three-stage input synchroniser that accepts a change once the last two stages agree.
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter logic RESET_VAL = 1'b1
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic pin_in,
  output logic level_out
);

  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  wire agree = (s2_reg == s3_reg);

  // The first stage feeds only the second, so a metastable sample never reaches logic.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s1_reg <= RESET_VAL;
      s2_reg <= RESET_VAL;
      s3_reg <= RESET_VAL;
      level_out <= RESET_VAL;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (agree) begin
        level_out <= s3_reg;
      end
    end
  end

endmodule

`default_nettype wire

/* File: hw/crc8_byte.sv */
// One byte step of the payload check code.
`timescale 1ns/1ps
`default_nettype none
`include "readout_defines.svh"

module crc8_byte (
  input wire logic [7:0] crc_in,
  input wire logic [7:0] data_in,
  output logic [7:0] crc_out
);

  // Most significant bit first, generator x^8 + x^5 + x^4 + 1.
  always_comb begin
    logic [7:0] c;
    c = crc_in ^ data_in;
    for (int i = 0; i < 8; i++) begin
      if (c[7]) begin
        c = {c[6:0], 1'b0} ^ `RDO_CRC_POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    crc_out = c;
  end

endmodule

`default_nettype wire

/* File: hw/humidity_temp_measure_readout.sv */
// Two-wire slave and measurement sequencer of a humidity and temperature sensor.
`timescale 1ns/1ps
`default_nettype none
`include "readout_defines.svh"

module humidity_temp_measure_readout #(
  parameter int unsigned CONV_CYCLES = `RDO_CONV_CYCLES,
  parameter logic [6:0] DEV_ADDR = `RDO_DEV_ADDR
) (
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic [19:0] humidity_raw_in,
  input wire logic [19:0] temperature_raw_in,
  input wire logic otp_crc_ok_in,
  input wire logic calibration_enable_in,
  input wire logic threshold_out_of_window_in,
  input wire logic [1:0] work_mode_in,
  output logic [7:0] measurement_status_out,
  output logic [19:0] humidity_raw_out,
  output logic [19:0] temperature_raw_out,
  output logic busy_out,
  output logic asleep_out
);

  localparam logic [23:0] CONV_LAST = 24'(CONV_CYCLES - 1);

  // ========================================================================
  // Pin synchronisation and bus event detection
  logic scl_s;
  logic sda_s;
  logic scl_q_reg;
  logic sda_q_reg;

  pin_sync #(.RESET_VAL(1'b1)) u_scl_sync (
    .clk_in(mclk_in),
    .resetn_in(resetn_in),
    .pin_in(scl_in),
    .level_out(scl_s)
  );

  pin_sync #(.RESET_VAL(1'b1)) u_sda_sync (
    .clk_in(mclk_in),
    .resetn_in(resetn_in),
    .pin_in(sda_in),
    .level_out(sda_s)
  );

  // SCL is oversampled here rather than used as a clock: start and stop are
  // SDA edges while SCL is high, which an SCL-clocked register cannot see.
  wire scl_rise = scl_s & ~scl_q_reg;
  wire scl_fall = ~scl_s & scl_q_reg;
  wire start_det = scl_s & scl_q_reg & sda_q_reg & ~sda_s;
  wire stop_det = scl_s & scl_q_reg & ~sda_q_reg & sda_s;

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      scl_q_reg <= 1'b1;
      sda_q_reg <= 1'b1;
    end else begin
      scl_q_reg <= scl_s;
      sda_q_reg <= sda_s;
    end
  end

  // ========================================================================
  // Bus engine registers
  readout_pkg::link_state_t state_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] tx_reg;
  logic rw_reg;
  logic [2:0] byte_idx_reg;
  logic trig_ok_reg;
  logic drive_reg;
  logic [7:0] crc_reg;
  logic [7:0] snap_status_reg;
  logic [19:0] snap_hum_reg;
  logic [19:0] snap_temp_reg;

  // ========================================================================
  // Measurement engine registers
  readout_pkg::meas_state_t meas_reg;
  logic [23:0] conv_cnt_reg;

  // ========================================================================
  // Payload selection
  function automatic logic [7:0] trig_byte(input logic [2:0] idx);
    case (idx)
      3'h0: trig_byte = `RDO_TRIG_BYTE0;
      3'h1: trig_byte = `RDO_TRIG_BYTE1;
      default: trig_byte = `RDO_TRIG_BYTE2;
    endcase
  endfunction

  function automatic logic [7:0] read_byte(input logic [2:0] idx, input logic [7:0] st,
                                           input logic [19:0] hum, input logic [19:0] tmp,
                                           input logic [7:0] crc);
    case (idx)
      3'h0: read_byte = st;
      3'h1: read_byte = hum[19:12];
      3'h2: read_byte = hum[11:4];
      3'h3: read_byte = {hum[3:0], tmp[19:16]};
      3'h4: read_byte = tmp[15:8];
      3'h5: read_byte = tmp[7:0];
      3'h6: read_byte = crc;
      default: read_byte = `RDO_FILL_BYTE;
    endcase
  endfunction

  // Status is assembled live; bits 1:0 always read as zero.
  wire busy_now = (meas_reg == readout_pkg::MEAS_CONVERT);
  wire [7:0] status_now = {busy_now,
                           work_mode_in,
                           otp_crc_ok_in,
                           calibration_enable_in,
                           threshold_out_of_window_in,
                           `RDO_ST_RSVD};

  wire [7:0] cur_byte = read_byte(byte_idx_reg, snap_status_reg, snap_hum_reg, snap_temp_reg,
                                  crc_reg);
  wire [7:0] crc_step;

  crc8_byte u_crc (
    .crc_in(crc_reg),
    .data_in(cur_byte),
    .crc_out(crc_step)
  );

  wire addr_match = (shift_reg[7:1] == DEV_ADDR);
  wire byte_done = (bit_cnt_reg == 4'h8);
  wire trig_match = trig_ok_reg & (shift_reg == trig_byte(byte_idx_reg));
  wire wake = (state_reg == readout_pkg::LINK_ADDR) & scl_fall & byte_done & addr_match;
  wire conv_start = (state_reg == readout_pkg::LINK_WRITE) & scl_fall & byte_done &
                    trig_match & (byte_idx_reg == `RDO_TRIG_LAST_IDX);
  wire conv_done = (meas_reg == readout_pkg::MEAS_CONVERT) & (conv_cnt_reg == CONV_LAST);
  wire crc_covers = (byte_idx_reg < `RDO_CRC_IDX);
  wire [2:0] idx_inc = (byte_idx_reg == `RDO_READ_BYTES) ? byte_idx_reg : byte_idx_reg + 3'h1;

  // ========================================================================
  // Bus engine
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_reg <= readout_pkg::LINK_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      tx_reg <= 8'h00;
      rw_reg <= 1'b0;
      byte_idx_reg <= 3'h0;
      trig_ok_reg <= 1'b0;
      drive_reg <= 1'b0;
      crc_reg <= `RDO_CRC_INIT;
      snap_status_reg <= `RDO_STATUS_RESET;
      snap_hum_reg <= 20'h00000;
      snap_temp_reg <= 20'h00000;
    end else if (start_det) begin
      state_reg <= readout_pkg::LINK_ADDR;
      bit_cnt_reg <= 4'h0;
      drive_reg <= 1'b0;
    end else if (stop_det) begin
      state_reg <= readout_pkg::LINK_IDLE;
      drive_reg <= 1'b0;
    end else begin
      case (state_reg)
        readout_pkg::LINK_ADDR, readout_pkg::LINK_WRITE: begin
          if (scl_rise && !byte_done) begin
            shift_reg <= {shift_reg[6:0], sda_s};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (scl_fall && byte_done) begin
            if (state_reg == readout_pkg::LINK_WRITE) begin
              trig_ok_reg <= trig_match;
              byte_idx_reg <= idx_inc;
              drive_reg <= 1'b1;
              state_reg <= readout_pkg::LINK_WRITE_ACK;
            end else if (addr_match) begin
              rw_reg <= shift_reg[0];
              byte_idx_reg <= 3'h0;
              trig_ok_reg <= 1'b1;
              crc_reg <= `RDO_CRC_INIT;
              // Snapshot so a conversion finishing mid-read cannot tear the payload.
              snap_status_reg <= status_now;
              snap_hum_reg <= humidity_raw_out;
              snap_temp_reg <= temperature_raw_out;
              drive_reg <= 1'b1;
              state_reg <= readout_pkg::LINK_ADDR_ACK;
            end else begin
              state_reg <= readout_pkg::LINK_IDLE;
            end
          end
        end
        readout_pkg::LINK_ADDR_ACK, readout_pkg::LINK_READ_ACK: begin
          if (scl_rise && state_reg == readout_pkg::LINK_READ_ACK && sda_s) begin
            state_reg <= readout_pkg::LINK_IDLE;
          end else if (scl_fall && (rw_reg || state_reg == readout_pkg::LINK_READ_ACK)) begin
            tx_reg <= cur_byte;
            drive_reg <= ~cur_byte[7];
            bit_cnt_reg <= 4'h1;
            byte_idx_reg <= idx_inc;
            if (crc_covers) begin
              crc_reg <= crc_step;
            end
            state_reg <= readout_pkg::LINK_READ;
          end else if (scl_fall) begin
            drive_reg <= 1'b0;
            bit_cnt_reg <= 4'h0;
            state_reg <= readout_pkg::LINK_WRITE;
          end
        end
        readout_pkg::LINK_WRITE_ACK: begin
          if (scl_fall) begin
            drive_reg <= 1'b0;
            bit_cnt_reg <= 4'h0;
            state_reg <= readout_pkg::LINK_WRITE;
          end
        end
        readout_pkg::LINK_READ: begin
          if (scl_fall && byte_done) begin
            drive_reg <= 1'b0;
            state_reg <= readout_pkg::LINK_READ_ACK;
          end else if (scl_fall) begin
            drive_reg <= ~tx_reg[6];
            tx_reg <= {tx_reg[6:0], 1'b0};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
        end
        default: begin
          drive_reg <= 1'b0;
        end
      endcase
    end
  end

  // ========================================================================
  // Measurement engine
  // A trigger during a running conversion restarts it; results stay those of
  // the last completed conversion until the new one ends.
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      meas_reg <= readout_pkg::MEAS_AWAKE;
      conv_cnt_reg <= 24'h000000;
      humidity_raw_out <= 20'h00000;
      temperature_raw_out <= 20'h00000;
    end else if (conv_start) begin
      meas_reg <= readout_pkg::MEAS_CONVERT;
      conv_cnt_reg <= 24'h000000;
    end else begin
      case (meas_reg)
        readout_pkg::MEAS_CONVERT: begin
          conv_cnt_reg <= conv_cnt_reg + 24'h000001;
          if (conv_done) begin
            humidity_raw_out <= humidity_raw_in;
            temperature_raw_out <= temperature_raw_in;
            meas_reg <= readout_pkg::MEAS_SLEEP;
          end
        end
        readout_pkg::MEAS_SLEEP: begin
          if (wake) begin
            meas_reg <= readout_pkg::MEAS_AWAKE;
          end
        end
        default: begin
          conv_cnt_reg <= 24'h000000;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      measurement_status_out <= `RDO_STATUS_RESET;
    end else begin
      measurement_status_out <= status_now;
    end
  end

  // ========================================================================
  // Pin and status outputs
  // The pin is open drain: only a low is ever driven.
  assign sda_out = 1'b0;
  assign sda_oe_out = drive_reg;
  assign busy_out = busy_now;
  assign asleep_out = (meas_reg == readout_pkg::MEAS_SLEEP);

endmodule

`default_nettype wire

/* File: tb/readout_checker.sv */
// Checker for the readout: status byte, result hold and conversion length.
`timescale 1ns/1ps
`default_nettype none

module readout_checker #(
  parameter int unsigned CONV_CYCLES = 200
) (
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic [19:0] humidity_raw_in,
  input wire logic otp_crc_ok_in,
  input wire logic calibration_enable_in,
  input wire logic threshold_out_of_window_in,
  input wire logic [1:0] work_mode_in,
  input wire logic [7:0] measurement_status_out,
  input wire logic [19:0] humidity_raw_out,
  input wire logic busy_out,
  input wire logic asleep_out
);
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!resetn_in);
  // ==========
  // Busy length; two cycles of slack cover the skew between counter and state.
  logic [31:0] busy_cnt_reg;
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      busy_cnt_reg <= 32'h0;
    end else begin
      busy_cnt_reg <= busy_out ? busy_cnt_reg + 32'h1 : 32'h0;
    end
  end
  property p_conv_len;
    $fell(busy_out) |-> busy_cnt_reg + 2 >= CONV_CYCLES && busy_cnt_reg <= CONV_CYCLES + 2;
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length off");
  property p_sleep;
    $fell(busy_out) |-> asleep_out;
  endproperty
  a_sleep: assert property (p_sleep) else $error("no sleep after conversion");
  property p_capture;
    $fell(busy_out) |-> humidity_raw_out == $past(humidity_raw_in);
  endproperty
  a_capture: assert property (p_capture) else $error("result not latched");
  property p_hold;
    busy_out |-> $stable(humidity_raw_out);
  endproperty
  a_hold: assert property (p_hold) else $error("result changed while busy");
  // ==========
  // Status byte, one cycle behind its sources
  property p_busy_bit;
    $past(resetn_in) |-> measurement_status_out[7] == $past(busy_out);
  endproperty
  a_busy_bit: assert property (p_busy_bit) else $error("busy bit wrong");
  property p_mode;
    $past(resetn_in) |-> ($past(work_mode_in) == 2'h3 ? measurement_status_out[6]
      : measurement_status_out[6:5] == $past(work_mode_in));
  endproperty
  a_mode: assert property (p_mode) else $error("mode bits wrong");
  property p_otp;
    $past(resetn_in) |-> measurement_status_out[4] == $past(otp_crc_ok_in);
  endproperty
  a_otp: assert property (p_otp) else $error("memory check bit wrong");
  property p_cal;
    $past(resetn_in) |-> measurement_status_out[3] == $past(calibration_enable_in);
  endproperty
  a_cal: assert property (p_cal) else $error("calibration bit wrong");
  property p_win;
    $past(resetn_in) |-> measurement_status_out[2] == $past(threshold_out_of_window_in);
  endproperty
  a_win: assert property (p_win) else $error("window bit wrong");
  property p_rsvd;
    measurement_status_out[1:0] == 2'h0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
endmodule

bind humidity_temp_measure_readout readout_checker #(.CONV_CYCLES(CONV_CYCLES)) chk_i (
  .mclk_in(mclk_in), .resetn_in(resetn_in), .humidity_raw_in(humidity_raw_in),
  .otp_crc_ok_in(otp_crc_ok_in), .calibration_enable_in(calibration_enable_in),
  .threshold_out_of_window_in(threshold_out_of_window_in), .work_mode_in(work_mode_in),
  .measurement_status_out(measurement_status_out), .humidity_raw_out(humidity_raw_out),
  .busy_out(busy_out), .asleep_out(asleep_out));
`default_nettype wire

/* File: tb/i2c_host_model.sv */
// Two-wire bus master model standing in for the host controller.
`timescale 1ns/1ps
`default_nettype none

module i2c_host_model (
  input wire logic link_clk_in,
  input wire logic sda_in,
  output var logic scl_out,
  output var logic sda_low_out
);
  // Quarter bit time in link clock cycles; the bench raises it for a slow host.
  int q = 4;
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  task automatic tick();
    repeat (q) @(posedge link_clk_in);
  endtask
  // Data moves only while the bus clock is low, so no false start or stop is seen.
  task automatic bit_io(input logic b, output logic r);
    sda_low_out = !b;
    tick();
    scl_out = 1'b1;
    tick();
    r = sda_in;
    tick();
    scl_out = 1'b0;
    tick();
  endtask
  task automatic start();
    tick();
    sda_low_out = 1'b1;
    tick();
    scl_out = 1'b0;
    tick();
  endtask
  task automatic stop();
    sda_low_out = 1'b1;
    tick();
    scl_out = 1'b1;
    tick();
    sda_low_out = 1'b0;
    tick();
  endtask
  task automatic wr(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic rd(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(last, r);
  endtask
endmodule
`default_nettype wire

/* File: tb/humidity_temp_measure_readout_tb.sv */
// Self-checking bench: triggers, conversions and reads through a host model.
`timescale 1ns/1ps
`default_nettype none

module humidity_temp_measure_readout_tb;
  localparam int unsigned CONV = 3000;
  // Power-up wait, scaled down with the conversion time to keep the run short.
  localparam int unsigned PWRUP = 625;
  typedef struct {
    logic [19:0] h;
    logic [19:0] t;
    logic [4:0] f;
  } row_t;
  row_t rows [4] = '{'{20'h80000, 20'h2ffab, 5'h06}, '{20'h00000, 20'hfffff, 5'h0b},
    '{20'hfffff, 20'h00001, 5'h15}, '{20'h12345, 20'habcde, 5'h18}};
  logic mclk_in = 1'b0;
  logic link_clk = 1'b0;
  logic resetn_in = 1'b0;
  logic [19:0] humidity_raw_in = 20'h0;
  logic [19:0] temperature_raw_in = 20'h0;
  logic otp_crc_ok_in = 1'b0;
  logic calibration_enable_in = 1'b0;
  logic threshold_out_of_window_in = 1'b0;
  logic [1:0] work_mode_in = 2'h0;
  logic scl, host_low, sda_out, sda_oe_out, busy_out, asleep_out;
  logic [7:0] measurement_status_out;
  logic [19:0] humidity_raw_out, temperature_raw_out;
  int fail_count = 0;
  int samples_checked = 0;
  logic [55:0] last_rd;
  wire sda_w;

  always #4 mclk_in = ~mclk_in;
  // Offset start keeps host clock edges clear of system clock edges.
  initial begin
    #1.3;
    forever #6 link_clk = ~link_clk;
  end
  // Pulled-up data line: low whenever either party pulls it.
  assign sda_w = (sda_oe_out && !sda_out) || host_low ? 1'b0 : 1'b1;

  humidity_temp_measure_readout #(.CONV_CYCLES(CONV)) humidity_temp_measure_readout_i (
    .mclk_in(mclk_in), .resetn_in(resetn_in), .scl_in(scl), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe_out(sda_oe_out), .humidity_raw_in(humidity_raw_in),
    .temperature_raw_in(temperature_raw_in), .otp_crc_ok_in(otp_crc_ok_in),
    .calibration_enable_in(calibration_enable_in),
    .threshold_out_of_window_in(threshold_out_of_window_in), .work_mode_in(work_mode_in),
    .measurement_status_out(measurement_status_out), .humidity_raw_out(humidity_raw_out),
    .temperature_raw_out(temperature_raw_out), .busy_out(busy_out), .asleep_out(asleep_out));
  i2c_host_model i2c_host_model_i (.link_clk_in(link_clk), .sda_in(sda_w), .scl_out(scl),
    .sda_low_out(host_low));

  // ==========
  // Helpers
  task automatic stop_test();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [55:0] e, input logic [55:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  function automatic logic [7:0] crc8(input logic [47:0] v);
    logic [7:0] c;
    c = 8'hff;
    for (int i = 47; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ v[i]) ? 8'h31 : 8'h00);
    end
    return c;
  endfunction
  // Host-side scaling in hundredths, truncated as integer firmware would do it.
  function automatic int rh_centi(input logic [19:0] r);
    return int'((64'(r) * 64'h2710) >> 20);
  endfunction
  function automatic int t_centi(input logic [19:0] r);
    return int'((64'(r) * 64'h4e20) >> 20) - 32'sh1388;
  endfunction
  // A result is only used when its check byte matches and no conversion was running.
  function automatic logic accept(input logic [55:0] v);
    return (crc8(v[55:8]) == v[7:0]) && !v[55];
  endfunction
  task automatic wb(input logic [7:0] d, input logic exp);
    logic a;
    i2c_host_model_i.wr(d, a);
    chk("ack", 56'(exp), 56'(a));
  endtask
  task automatic trig(input logic [7:0] b1);
    i2c_host_model_i.start();
    wb(8'h70, 1'b1);
    wb(8'hac, 1'b1);
    wb(b1, 1'b1);
    wb(8'h00, 1'b1);
    i2c_host_model_i.stop();
  endtask
  task automatic rd_chk(input logic [7:0] s, input logic [19:0] h, input logic [19:0] t);
    logic [55:0] g;
    logic [7:0] d;
    i2c_host_model_i.start();
    wb(8'h71, 1'b1);
    for (int i = 0; i < 7; i++) begin
      i2c_host_model_i.rd(i == 6, d);
      g = {g[47:0], d};
    end
    i2c_host_model_i.stop();
    // Bit 5 is free in command mode, so the seen value stands there.
    if (s[6]) begin
      s[5] = g[53];
    end
    last_rd = g;
    chk("readout", {s, h, t, crc8({s, h, t})}, g);
  endtask
  task automatic put(input row_t r);
    @(negedge mclk_in);
    {humidity_raw_in, temperature_raw_in} = {r.h, r.t};
    {work_mode_in, otp_crc_ok_in, calibration_enable_in, threshold_out_of_window_in} = r.f;
  endtask
  task automatic settle();
    repeat (CONV + 50) @(posedge mclk_in);
    @(negedge mclk_in);
    chk("asleep", 56'h1, {54'h0, busy_out, asleep_out});
  endtask
  task automatic chk_idle();
    chk("idle", 56'h0, {6'h0, busy_out, asleep_out, measurement_status_out, humidity_raw_out,
      temperature_raw_out});
  endtask

  // ==========
  // Main sequence
  initial begin
    repeat (8) @(posedge mclk_in);
    @(negedge mclk_in);
    chk_idle();
    resetn_in = 1'b1;
    repeat (PWRUP) @(posedge mclk_in);
    foreach (rows[k]) begin
      put(rows[k]);
      trig(8'h33);
      settle();
      rd_chk({1'b0, rows[k].f, 2'h0}, rows[k].h, rows[k].t);
      chk("awake", 56'h0, 56'(asleep_out));
    end
    chk("rh_scale", 56'h2c7, 56'(rh_centi(last_rd[47:28])));
    chk("t_scale", 56'h20e6, 56'(t_centi(last_rd[27:8])));
    chk("accept", 56'h1, 56'(accept(last_rd)));
    chk("crc_bad", 56'h0, 56'(accept(last_rd ^ 56'h1)));
    put('{20'h55555, 20'haaaaa, 5'h00});
    trig(8'h33);
    rd_chk(8'h80, 20'h12345, 20'habcde);
    chk("accept_busy", 56'h0, 56'(accept(last_rd)));
    settle();
    i2c_host_model_i.q = 8;
    rd_chk(8'h00, 20'h55555, 20'haaaaa);
    trig(8'h34);
    chk("no_conv", 56'h0, 56'(busy_out));
    i2c_host_model_i.start();
    wb(8'h72, 1'b0);
    i2c_host_model_i.stop();
    trig(8'h33);
    @(negedge mclk_in);
    resetn_in = 1'b0;
    @(negedge mclk_in);
    chk_idle();
    resetn_in = 1'b1;
    repeat (2) @(posedge mclk_in);
    @(negedge mclk_in);
    chk_idle();
    stop_test();
  end
  initial begin
    repeat (90000) @(posedge mclk_in);
    fail_count++;
    stop_test();
  end
endmodule
`default_nettype wire
